/* File: hdl/bgd_params.svh */
// Constants for the bridge gate dead-time controller: offsets, reset values, timing.
// Assumes a 20 MHz ref_clk; cycle counts derive from the period below.
`ifndef BGD_PARAMS_SVH
`define BGD_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define BGD_OFF_STATUS 8'h00
`define BGD_OFF_MASK 8'h04
`define BGD_OFF_DEAD 8'h08
`define BGD_OFF_GATES 8'h0C

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define BGD_STATUS_RST 10'h000
`define BGD_MASK_RST 10'h000
`define BGD_DEAD_RST 8'h00
`define BGD_STATUS_W 10
`define BGD_GATES_CHG_LSB 6

// ----------------------------------------
// Timing: figures as printed, then cycle counts
// ----------------------------------------
`define BGD_CLK_NS 50
`define BGD_DEAD_MAX_NS 6000
`define BGD_COMP_NS 300
`define BGD_BLANK_ZERO_NS 2000
`define BGD_CHG_MIN_NS 7000
`define BGD_BOOT_TO_NS 200000
`define BGD_DEAD_MAX_CYC ((`BGD_DEAD_MAX_NS + `BGD_CLK_NS - 1) / `BGD_CLK_NS)
`define BGD_COMP_CYC ((`BGD_COMP_NS + `BGD_CLK_NS - 1) / `BGD_CLK_NS)
`define BGD_BLANK_ZERO_CYC ((`BGD_BLANK_ZERO_NS + `BGD_CLK_NS - 1) / `BGD_CLK_NS)
`define BGD_CHG_MIN_CYC ((`BGD_CHG_MIN_NS + `BGD_CLK_NS - 1) / `BGD_CLK_NS)
`define BGD_BOOT_TO_CYC (`BGD_BOOT_TO_NS / `BGD_CLK_NS)

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define BGD_RESP_OKAY 2'b00
`define BGD_RESP_SLVERR 2'b10

`endif

/* File: hdl/bgd_pkg.sv */
// Types shared by the bridge gate dead-time controller.
// Assumes the constants header is compiled alongside.
package bgd_pkg;

    // Fault layout: bit 0 phase A high side ... bit 9 phase C bootstrap
    typedef struct packed {
        logic [2:0] boot_low;
        logic reserved;
        logic [2:0] short_lo;
        logic [2:0] short_hi;
    } bgd_fault_s;

    typedef enum logic [0:0] {
        BGD_CHG_IDLE = 1'b0,
        BGD_CHG_ON = 1'b1
    } bgd_charge_e;

endpackage

/* File: hdl/bgd_phase.sv */
// One half-bridge phase: dead interval, blanking, bootstrap recharge.
// Assumes all inputs are already synchronised to ref_clk.
`timescale 1ns/100ps
`include "bgd_params.svh"

module bgd_phase #(
    parameter int DEAD_W = 8,
    parameter int CHG_W = 12
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic srst, // sync reset
    input wire logic cmd_hi, // high side on request
    input wire logic cmd_lo, // low side on request
    input wire logic [DEAD_W-1:0] dead_cyc, // dead interval, cycles
    input wire logic [DEAD_W:0] blank_cyc, // blanking window, cycles
    input wire logic overlap_ok, // both sides may conduct
    input wire logic boot_low, // bootstrap below threshold
    input wire logic boot_ok, // bootstrap above upper threshold
    input wire logic ds_hi, // high side short monitor
    input wire logic ds_lo, // low side short monitor
    output logic gate_hi, // high side gate
    output logic gate_lo, // low side gate
    output logic charging, // recharge in progress
    output logic short_hi, // high side short event
    output logic short_lo, // low side short event
    output logic boot_fault // recharge timeout pulse
);
    import bgd_pkg::*;

    if (`BGD_BOOT_TO_CYC >= (2 ** CHG_W)) begin : g_bad_chg
        $error("CHG_W too small for recharge timeout");
    end

    // Index 0 is the low side, 1 the high side
    logic [1:0] req;
    logic [1:0] gate;
    logic [1:0] next_gate;
    logic [1:0] ds;
    logic [DEAD_W-1:0] hold [2];
    logic [DEAD_W:0] blank [2];
    bgd_charge_e chg_state;
    logic [CHG_W-1:0] chg_cnt;

    assign charging = (chg_state == BGD_CHG_ON);
    assign req = {cmd_hi & ~charging, cmd_lo | charging};
    assign ds = {ds_hi, ds_lo};
    assign gate_hi = gate[1];
    assign gate_lo = gate[0];

    // Low side wins a tie so a recharge is never starved
    always_comb begin
        next_gate[0] = req[0] && (hold[0] == '0) && (overlap_ok || !gate[1]);
        next_gate[1] = req[1] && (hold[1] == '0)
            && (overlap_ok || (!gate[0] && !req[0]));
    end

    for (genvar s = 0; s < 2; s++) begin : g_side
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                gate[s] <= 1'b0;
            end else begin
                gate[s] <= next_gate[s];
            end
        end

        // Hold-off only while the complement's off edge is recent
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                hold[s] <= '0;
            end else if (gate[1-s] && !next_gate[1-s]) begin
                hold[s] <= dead_cyc;
            end else if (hold[s] != '0) begin
                hold[s] <= hold[s] - DEAD_W'(1);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                blank[s] <= '0;
            end else if (next_gate[s] && !gate[s]) begin
                blank[s] <= blank_cyc;
            end else if (blank[s] != '0) begin
                blank[s] <= blank[s] - (DEAD_W + 1)'(1);
            end
        end
    end

    assign short_lo = gate[0] && (blank[0] == '0) && ds[0];
    assign short_hi = gate[1] && (blank[1] == '0) && ds[1];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            chg_state <= BGD_CHG_IDLE;
            chg_cnt <= '0;
            boot_fault <= 1'b0;
        end else begin
            boot_fault <= 1'b0;
            case (chg_state)
                BGD_CHG_IDLE: begin
                    chg_cnt <= '0;
                    if (boot_low) begin
                        chg_state <= BGD_CHG_ON;
                    end
                end
                BGD_CHG_ON: begin
                    chg_cnt <= chg_cnt + CHG_W'(1);
                    if (boot_ok && chg_cnt >= CHG_W'(`BGD_CHG_MIN_CYC - 1)) begin
                        chg_state <= BGD_CHG_IDLE;
                    end else if (chg_cnt == CHG_W'(`BGD_BOOT_TO_CYC - 1)) begin
                        boot_fault <= 1'b1;
                        chg_state <= BGD_CHG_IDLE;
                    end
                end
                default: begin
                    chg_state <= BGD_CHG_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: hdl/bgd_gate_ctrl.sv */
// Three-phase gate command sequencer with an AXI4-Lite register slave.
// Assumes pin inputs are asynchronous and are synchronised here;
// one AXI write and one read outstanding at a time.
`timescale 1ns/100ps
`include "bgd_params.svh"

module bgd_gate_ctrl #(
    parameter int ADDR_W = 8,
    parameter int DEAD_W = 8,
    parameter int CHG_W = 12
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic srst, // sync reset, high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [2:0] phase_hi_cmd, // high side commands, A..C
    input wire logic [2:0] phase_lo_cmd, // low side commands, A..C
    input wire logic [1:0] dead_interval_select, // 00 zero, 11 max, else reg
    input wire logic overlap_permit_input, // overlap permit pin
    input wire logic [2:0] boot_below, // bootstrap under threshold
    input wire logic [2:0] boot_above, // bootstrap above upper threshold
    input wire logic [2:0] ds_mon_hi, // high side short monitors
    input wire logic [2:0] ds_mon_lo, // low side short monitors
    output logic [2:0] gate_hi, // high side gate drive
    output logic [2:0] gate_lo, // low side gate drive
    output logic irq // level interrupt
);
    import bgd_pkg::*;

    if (`BGD_DEAD_MAX_CYC >= (2 ** DEAD_W)) begin : g_bad_dead
        $error("DEAD_W too small for maximum dead interval");
    end
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W too small for register map");
    end

    localparam int NIN = 21;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [NIN-1:0] pin_meta;
    logic [NIN-1:0] pin_sync;
    logic [2:0] hi_cmd_s;
    logic [2:0] lo_cmd_s;
    logic [1:0] dsel_s;
    logic permit_s;
    logic [2:0] below_s;
    logic [2:0] above_s;
    logic [2:0] dsh_s;
    logic [2:0] dsl_s;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {phase_hi_cmd, phase_lo_cmd, dead_interval_select,
                overlap_permit_input, boot_below, boot_above, ds_mon_hi, ds_mon_lo};
            pin_sync <= pin_meta;
        end
    end

    assign {hi_cmd_s, lo_cmd_s, dsel_s, permit_s, below_s, above_s, dsh_s, dsl_s} = pin_sync;

    // ----------------------------------------
    // Dead interval and blanking selection
    // ----------------------------------------
    logic [DEAD_W-1:0] dead_reg;
    logic [DEAD_W-1:0] dead_cyc;
    logic [DEAD_W:0] blank_cyc;
    logic dead_zero;
    logic overlap_ok;

    // Middle strap codes stand in for a resistor; software sets the length
    always_comb begin
        if (dsel_s == 2'b00) begin
            dead_cyc = '0;
        end else if (dsel_s == 2'b11) begin
            dead_cyc = DEAD_W'(`BGD_DEAD_MAX_CYC);
        end else begin
            dead_cyc = dead_reg;
        end
    end

    assign dead_zero = (dead_cyc == '0);

    always_comb begin
        if (dead_zero) begin
            blank_cyc = (DEAD_W + 1)'(`BGD_BLANK_ZERO_CYC);
        end else begin
            blank_cyc = {1'b0, dead_cyc} + (DEAD_W + 1)'(`BGD_COMP_CYC);
        end
    end

    // Zero dead time leaves spacing to the controller
    assign overlap_ok = dead_zero && permit_s;

    // ----------------------------------------
    // Phases
    // ----------------------------------------
    logic [2:0] chg;
    logic [2:0] sh_ev;
    logic [2:0] sl_ev;
    logic [2:0] bf_ev;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        bgd_phase #(
            .DEAD_W(DEAD_W),
            .CHG_W(CHG_W)
        ) u_phase (
            .ref_clk(ref_clk),
            .srst(srst),
            .cmd_hi(hi_cmd_s[p]),
            .cmd_lo(lo_cmd_s[p]),
            .dead_cyc(dead_cyc),
            .blank_cyc(blank_cyc),
            .overlap_ok(overlap_ok),
            .boot_low(below_s[p]),
            .boot_ok(above_s[p]),
            .ds_hi(dsh_s[p]),
            .ds_lo(dsl_s[p]),
            .gate_hi(gate_hi[p]),
            .gate_lo(gate_lo[p]),
            .charging(chg[p]),
            .short_hi(sh_ev[p]),
            .short_lo(sl_ev[p]),
            .boot_fault(bf_ev[p])
        );
    end

    // ----------------------------------------
    // Fault status and interrupt
    // ----------------------------------------
    bgd_fault_s status;
    bgd_fault_s mask;
    bgd_fault_s set_ev;
    logic [`BGD_STATUS_W-1:0] clr;

    assign set_ev = '{boot_low: bf_ev, reserved: 1'b0, short_lo: sl_ev, short_hi: sh_ev};

    // Set beats a same-cycle clear so no event is lost
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status <= `BGD_STATUS_RST;
        end else begin
            status <= (status & ~clr) | set_ev;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_value;
    logic [31:0] w_mask;
    logic write_do;
    logic [ADDR_W-1:0] wr_word;

    assign write_do = aw_got && w_got && !s_axi_bvalid;
    assign wr_word = {aw_addr[ADDR_W-1:2], 2'b00};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (write_do) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Byte lanes are kept as a mask and gate the data when the register is written
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b0;
            w_mask <= 32'h0000_0000;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b1;
            w_mask <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end else if (write_do) begin
            w_got <= 1'b0;
        end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            w_value <= 32'h0000_0000;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_value <= s_axi_wdata;
        end
    end

    assign clr = (write_do && wr_word == ADDR_W'(`BGD_OFF_STATUS))
        ? (w_value[`BGD_STATUS_W-1:0] & w_mask[`BGD_STATUS_W-1:0]) : '0;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask <= `BGD_MASK_RST;
            dead_reg <= DEAD_W'(`BGD_DEAD_RST);
        end else if (write_do) begin
            if (wr_word == ADDR_W'(`BGD_OFF_MASK)) begin
                mask <= (mask & ~w_mask[`BGD_STATUS_W-1:0])
                    | (w_value[`BGD_STATUS_W-1:0] & w_mask[`BGD_STATUS_W-1:0]);
            end else if (wr_word == ADDR_W'(`BGD_OFF_DEAD)) begin
                if (w_mask[0]) begin
                    dead_reg <= w_value[DEAD_W-1:0];
                end
            end
        end
    end

    logic wr_hit;

    always_comb begin
        if (wr_word == ADDR_W'(`BGD_OFF_STATUS)) begin
            wr_hit = 1'b1;
        end else if (wr_word == ADDR_W'(`BGD_OFF_MASK)) begin
            wr_hit = 1'b1;
        end else if (wr_word == ADDR_W'(`BGD_OFF_DEAD)) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BGD_RESP_OKAY;
        end else if (write_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `BGD_RESP_OKAY : `BGD_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic [ADDR_W-1:0] rd_word;
    logic [31:0] rd_val;
    logic rd_hit;

    assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};

    always_comb begin
        rd_hit = 1'b1;
        if (rd_word == ADDR_W'(`BGD_OFF_STATUS)) begin
            rd_val = 32'(status);
        end else if (rd_word == ADDR_W'(`BGD_OFF_MASK)) begin
            rd_val = 32'(mask);
        end else if (rd_word == ADDR_W'(`BGD_OFF_DEAD)) begin
            rd_val = 32'(dead_reg);
        end else if (rd_word == ADDR_W'(`BGD_OFF_GATES)) begin
            rd_val = 32'({chg, gate_lo, gate_hi});
        end else begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BGD_RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `BGD_RESP_OKAY : `BGD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* File: tb/bgd_gate_chk.sv */
// Checker for the gate sequencer: overlap, dead hold, recharge, bus answers.
// Assumes strap and permit pins stay steady while gates switch.
`timescale 1ns/100ps

module bgd_gate_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk, // clock
    input wire logic srst, // sync reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic [ADDR_W-1:0] s_axi_araddr, // ar address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r response
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [2:0] phase_hi_cmd, // high requests
    input wire logic [1:0] dead_interval_select, // strap
    input wire logic overlap_permit_input, // permit pin
    input wire logic [2:0] boot_below, // bootstrap low
    input wire logic [2:0] gate_hi, // high gates
    input wire logic [2:0] gate_lo, // low gates
    input wire logic irq // interrupt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // ----------------------------------------
    // Gate rules
    // ----------------------------------------
    chk_overlap_only: assert property ((gate_hi & gate_lo) != 3'h0 |->
        $past(dead_interval_select, 3) == 2'h0 && $past(overlap_permit_input, 3))
        else $error("both sides on without permission");
    chk_gate_request: assert property ((gate_hi & ~$past(gate_hi) & ~$past(phase_hi_cmd, 3)) == '0)
        else $error("high gate rose without request");
    chk_dead_hold: assert property ($fell(gate_hi[0]) && boot_below == 3'h0 &&
        $past(dead_interval_select, 2) == 2'h3 |=> !gate_lo[0] [*8])
        else $error("low gate inside dead interval");
    chk_recharge_on: assert property ($rose(boot_below[0]) ##1 boot_below[0] [*7]
        ##0 dead_interval_select == 2'h0 |-> gate_lo[0] && !gate_hi[0])
        else $error("recharge did not drive low side");
    // Reset check must run while reset is high, so no disable here
    chk_reset_quiet: assert property (disable iff (1'b0) srst |=> gate_hi == 3'h0 &&
        gate_lo == 3'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active in reset");

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 'h0C
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");

    cover property ((gate_hi & gate_lo) != 3'h0);
    cover property ($rose(irq));
    cover property ($fell(gate_hi[0]) ##[1:200] $rose(gate_lo[0]));
endmodule

bind bgd_gate_ctrl bgd_gate_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .phase_hi_cmd, .dead_interval_select, .overlap_permit_input,
    .boot_below, .gate_hi, .gate_lo, .irq);

/* File: tb/bgd_ctrl_model.sv */
// Motor controller model: turns bench requests into the six phase commands.
// Assumes requests change by non-blocking assignment after a clock edge.
`timescale 1ns/100ps

module bgd_ctrl_model (
    input wire logic ref_clk, // clock
    input wire logic [2:0] hi_req, // wanted high sides
    input wire logic [2:0] lo_req, // wanted low sides
    input wire logic [7:0] gap, // own dead cycles
    output logic [2:0] phase_hi_cmd = 3'h0, // to block
    output logic [2:0] phase_lo_cmd = 3'h0 // to block
);
    logic [7:0] cnt = 8'h00;
    wire drop = ((phase_hi_cmd & ~hi_req) | (phase_lo_cmd & ~lo_req)) != 3'h0;

    // Turn-offs pass at once, turn-ons wait out our own gap
    always_ff @(posedge ref_clk) begin
        if (drop) begin
            phase_hi_cmd <= phase_hi_cmd & hi_req;
            phase_lo_cmd <= phase_lo_cmd & lo_req;
            cnt <= gap;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else begin
            phase_hi_cmd <= hi_req;
            phase_lo_cmd <= lo_req;
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Bench for the gate sequencer: bus tasks, controller model, scenarios.
// Assumes design, checker and controller model are compiled first.
`timescale 1ns/100ps

module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, gap = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, overlap_permit_input = 1'b0;
    logic [1:0] dead_interval_select = 2'h0;
    logic [2:0] hi_req = 3'h0, lo_req = 3'h0, boot_below = 3'h0, ds_mon_hi = 3'h0;
    logic [2:0] boot_above = 3'h7; // Charged before any high side
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] phase_hi_cmd, phase_lo_cmd, gate_hi, gate_lo, ds_mon_lo = 3'h0;
    int n_fail = 0, comparisons = 0, cyc = 0;

    bgd_ctrl_model u_ctrl (.ref_clk, .hi_req, .lo_req, .gap, .phase_hi_cmd, .phase_lo_cmd);
    bgd_gate_ctrl dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phase_hi_cmd, .phase_lo_cmd,
        .dead_interval_select, .overlap_permit_input, .boot_below, .boot_above, .ds_mon_hi,
        .ds_mon_lo, .gate_hi, .gate_lo, .irq);

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 5000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(w, e, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_chk("status", 8'h00, 32'h0000_0000, 2'h0);
        rd_chk("mask", 8'h04, 32'h0000_0000, 2'h0);
        wr_chk(8'h08, 32'hFFFF_FF05, 2'h0);
        rd_chk("dead", 8'h08, 32'h0000_0005, 2'h0);
        wr_chk(8'h10, 32'h0000_0001, 2'h2);
        rd_chk("unmapped", 8'h10, 32'h0000_0000, 2'h2);
    endtask

    task automatic t_dead();
        dead_interval_select <= 2'h3;
        hi_req <= 3'h1;
        wait_cyc(10);
        hi_req <= 3'h0;
        lo_req <= 3'h1;
        wait_cyc(60);
        chk("lo in dead", 32'h0, 32'(gate_lo[0]));
        wait_cyc(80);
        chk("lo after dead", 32'h1, 32'(gate_lo[0]));
        rd_chk("gates", 8'h0C, 32'h0000_0008, 2'h0);
        lo_req <= 3'h0;
        wait_cyc(200);
        hi_req <= 3'h1;
        wait_cyc(8);
        chk("hi no dead", 32'h1, 32'(gate_hi[0]));
        dead_interval_select <= 2'h1;
        hi_req <= 3'h0;
        lo_req <= 3'h1;
        wait_cyc(7);
        chk("lo in reg dead", 32'h0, 32'(gate_lo[0]));
        wait_cyc(5);
        chk("lo after reg dead", 32'h1, 32'(gate_lo[0]));
        lo_req <= 3'h0;
        wait_cyc(10);
    endtask

    task automatic t_cross();
        dead_interval_select <= 2'h0;
        gap <= 8'h03;
        hi_req <= 3'h2;
        lo_req <= 3'h2;
        wait_cyc(10);
        chk("overlap blocked", 32'h1, 32'({gate_hi[1], gate_lo[1]}));
        overlap_permit_input <= 1'b1;
        wait_cyc(10);
        chk("overlap on", 32'h3, 32'({gate_hi[1], gate_lo[1]}));
        hi_req <= 3'h0;
        lo_req <= 3'h0;
        wait_cyc(10);
        overlap_permit_input <= 1'b0;
        gap <= 8'h00;
    endtask

    task automatic t_short();
        ds_mon_hi <= 3'h4;
        ds_mon_lo <= 3'h4;
        wait_cyc(20);
        hi_req <= 3'h4;
        wait_cyc(30);
        rd_chk("status blanked", 8'h00, 32'h0000_0000, 2'h0);
        wait_cyc(30);
        rd_chk("status short", 8'h00, 32'h0000_0004, 2'h0);
        chk("irq masked", 32'h0, 32'(irq));
        wr_chk(8'h04, 32'h0000_0004, 2'h0);
        wait_cyc(3);
        chk("irq on", 32'h1, 32'(irq));
        ds_mon_hi <= 3'h0;
        ds_mon_lo <= 3'h0;
        hi_req <= 3'h0;
        wait_cyc(4);
        wr_chk(8'h00, 32'h0000_0004, 2'h0);
        rd_chk("status clear", 8'h00, 32'h0000_0000, 2'h0);
        chk("irq off", 32'h0, 32'(irq));
    endtask

    task automatic t_boot();
        boot_above <= 3'h6;
        boot_below <= 3'h1;
        wait_cyc(10);
        boot_below <= 3'h0;
        boot_above <= 3'h7;
        wait_cyc(80);
        rd_chk("gates charge", 8'h0C, 32'h0000_0048, 2'h0);
        chk("charge min", 32'h1, 32'(gate_lo[0]));
        wait_cyc(70);
        chk("charge end", 32'h0, 32'(gate_lo[0]));
        boot_above <= 3'h6;
        boot_below <= 3'h1;
        wait_cyc(4020);
        rd_chk("boot fault", 8'h00, 32'h0000_0080, 2'h0);
        boot_below <= 3'h0;
        boot_above <= 3'h7;
        wait_cyc(200);
        wr_chk(8'h00, 32'h0000_0080, 2'h0);
        rd_chk("fault clear", 8'h00, 32'h0000_0000, 2'h0);
    endtask

    initial begin
        wait_cyc(8);
        srst <= 1'b0;
        wait_cyc(2);
        t_regs();
        t_dead();
        t_cross();
        t_short();
        t_boot();
        report_and_stop();
    end
endmodule
